// ---- rtl/sas_sar_adc_sequencer.sv ----
// SAR converter sequencer top
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_sar_adc_sequencer
   import sas_pkg::*;
#(
   parameter int SETTLE_CYC = `SAS_SETTLE_CYC
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic       i_hw_stop,
   input  wire logic       i_mode_we,
   input  wire logic [4:0] i_mode_wdata,
   input  wire logic       i_reference_voltage_input,
   input  wire logic       i_comp_higher,
   output logic [7:0]      o_tap_sel,
   output logic [2:0]      o_mux_sel,
   output logic [4:0]      o_channel_mode_register,
   output logic [7:0]      o_result_reg_0,
   output logic [7:0]      o_result_reg_1,
   output logic [7:0]      o_result_reg_2,
   output logic [7:0]      o_result_reg_3,
   output logic            o_conversion_done_irq,
   output logic            o_busy
);
   localparam int CW = $clog2(SETTLE_CYC + 1);

   sas_state_t  state_q, state_d;
   logic [4:0]  mode_q, mode_d;
   logic [7:0]  sar_q, sar_d;
   logic [7:0]  bit_q, bit_d;
   logic [1:0]  slot_q, slot_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [2:0]  mux_q, mux_d;
   logic        irq_q, irq_d;
   logic        busy_q, busy_d;
   sas_result_t wr;
   logic [7:0]  res [`SAS_NUM_RES];

   // Input channel for a given result slot
   function automatic logic [2:0] chan_for(input logic [4:0] m, input logic [1:0] s);
      if (m[`SAS_SCAN_SEL_BIT] == 1'b0) begin
         chan_for = {m[`SAS_GROUP_BIT], s};
      end else begin
         chan_for = m[`SAS_GROUP_BIT:`SAS_CH_LSB];
      end
   endfunction

   always_comb begin
      state_d = state_q;
      mode_d  = mode_q;
      sar_d   = sar_q;
      bit_d   = bit_q;
      slot_d  = slot_q;
      cnt_d   = cnt_q;
      irq_d   = 1'b0;
      wr      = '0;
      if (i_hw_stop) begin
         mode_d  = `SAS_MODE_RESET;
         state_d = SAS_IDLE;
         slot_d  = 2'h0;
         sar_d   = 8'h00;
      end else if (i_mode_we) begin
         mode_d  = i_mode_wdata;
         state_d = SAS_IDLE;
         slot_d  = 2'h0;
         sar_d   = 8'h00;
      end else if (!i_reference_voltage_input) begin
         // Halted: restart from slot 0 with mode kept
         state_d = SAS_IDLE;
         slot_d  = 2'h0;
         sar_d   = 8'h00;
      end else begin
         unique case (state_q)
            SAS_IDLE: begin
               sar_d   = 8'h80;
               bit_d   = 8'h80;
               cnt_d   = CW'(SETTLE_CYC);
               state_d = SAS_SETTLE;
            end
            SAS_SETTLE: begin
               cnt_d = cnt_q - CW'(1);
               if (cnt_q == CW'(1)) begin
                  state_d = SAS_DECIDE;
               end
            end
            SAS_DECIDE: begin
               if (!i_comp_higher) begin
                  sar_d = sar_q & ~bit_q;
               end
               if (bit_q[0]) begin
                  wr.we   = 1'b1;
                  wr.slot = slot_q;
                  wr.code = i_comp_higher ? sar_q : (sar_q & ~bit_q);
                  slot_d  = slot_q + 2'h1;
                  irq_d   = (slot_q == 2'h3);
                  state_d = SAS_IDLE;
               end else begin
                  bit_d   = bit_q >> 1;
                  sar_d   = (i_comp_higher ? sar_q : (sar_q & ~bit_q)) | (bit_q >> 1);
                  cnt_d   = CW'(SETTLE_CYC);
                  state_d = SAS_SETTLE;
               end
            end
         endcase
      end
      mux_d = chan_for(mode_d, slot_d);
      // Busy is registered so the output comes from a flop
      busy_d = (state_d != SAS_IDLE);
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_q <= SAS_IDLE;
         mode_q  <= `SAS_MODE_RESET;
         sar_q   <= 8'h00;
         bit_q   <= 8'h80;
         slot_q  <= 2'h0;
         cnt_q   <= '0;
         mux_q   <= 3'h0;
         irq_q   <= 1'b0;
         busy_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         mode_q  <= mode_d;
         sar_q   <= sar_d;
         bit_q   <= bit_d;
         slot_q  <= slot_d;
         cnt_q   <= cnt_d;
         mux_q   <= mux_d;
         irq_q   <= irq_d;
         busy_q  <= busy_d;
      end
   end

   sas_result_bank #(
      .NUM_RES (`SAS_NUM_RES)
   ) u_bank (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_wr      (wr),
      .o_res     (res)
   );

   assign o_tap_sel               = sar_q;
   assign o_mux_sel               = mux_q;
   assign o_channel_mode_register = mode_q;
   assign o_result_reg_0          = res[0];
   assign o_result_reg_1          = res[1];
   assign o_result_reg_2          = res[2];
   assign o_result_reg_3          = res[3];
   assign o_conversion_done_irq   = irq_q;
   assign o_busy                  = busy_q;

   // Assertions
   sequence s_decide_last;
      state_q == SAS_DECIDE && bit_q[0] && i_reference_voltage_input && !i_mode_we && !i_hw_stop;
   endsequence
   sequence s_irq_pulse;
      o_conversion_done_irq ##1 !o_conversion_done_irq;
   endsequence

   chk_start_half: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == SAS_IDLE && i_reference_voltage_input && !i_mode_we && !i_hw_stop |=> sar_q == 8'h80)
      else $error("trial did not start at half scale");
   chk_bit_walk: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == SAS_DECIDE && !bit_q[0] && i_reference_voltage_input && !i_mode_we && !i_hw_stop
      |=> bit_q == $past(bit_q) >> 1)
      else $error("bit step not one lower");
   chk_lower_trial: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == SAS_DECIDE && !bit_q[0] && i_reference_voltage_input && !i_mode_we && !i_hw_stop
      |=> (sar_q & (bit_q)) != 8'h00)
      else $error("next trial bit not set");
   chk_result_wr: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_decide_last |=> ##1 res[$past(slot_q, 2)] == $past(wr.code, 2))
      else $error("result not stored in slot");
   chk_irq_four: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      s_decide_last ##0 (slot_q == 2'h3) |=> s_irq_pulse)
      else $error("completion irq missing");
   chk_tap_follow: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == SAS_SETTLE && i_reference_voltage_input && !i_mode_we && !i_hw_stop
      |=> o_tap_sel == $past(o_tap_sel))
      else $error("tap select moved while settling");
   chk_mux_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      state_q == SAS_DECIDE |-> o_mux_sel == (mode_q[`SAS_SCAN_SEL_BIT] ?
         mode_q[`SAS_GROUP_BIT:`SAS_CH_LSB] : {mode_q[`SAS_GROUP_BIT], slot_q}))
      else $error("mux select wrong for mode");
   chk_ref_halt: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      !i_reference_voltage_input |=> state_q == SAS_IDLE && slot_q == 2'h0)
      else $error("low reference did not halt");
   chk_mode_restart: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_mode_we && !i_hw_stop |=> mode_q == $past(i_mode_wdata) && slot_q == 2'h0 && state_q == SAS_IDLE)
      else $error("mode write did not restart");
   chk_stop_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      i_hw_stop |=> mode_q == 5'h00)
      else $error("hardware stop did not clear mode");
   chk_settle_len: assert property (@(posedge i_clk_sys) disable iff (i_rst)
      $rose(state_q == SAS_SETTLE) && i_reference_voltage_input |-> cnt_q == CW'(SETTLE_CYC))
      else $error("settle count wrong");
endmodule

// ---- rtl/sas_params.svh ----
// Constants for the SAR converter sequencer
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
`define SAS_SAR_W        8
`define SAS_NUM_RES      4
`define SAS_MODE_W       5
`define SAS_MODE_RESET   5'h00
`define SAS_SCAN_SEL_BIT 0
`define SAS_CH_LSB       1
`define SAS_GROUP_BIT    3
`define SAS_SETTLE_NS    20
`define SAS_CLK_NS       5
`define SAS_SETTLE_CYC   ((`SAS_SETTLE_NS + `SAS_CLK_NS - 1) / `SAS_CLK_NS)
`endif

// ---- rtl/sas_pkg.sv ----
// Types for the SAR converter sequencer
package sas_pkg;
   typedef enum logic [1:0] {SAS_IDLE, SAS_SETTLE, SAS_DECIDE} sas_state_t;
   typedef struct packed {
      logic [7:0] code;
      logic [1:0] slot;
      logic       we;
   } sas_result_t;
endpackage

// ---- rtl/sas_result_bank.sv ----
// Four result registers filled in order
`timescale 1ns/1ps
`include "sas_params.svh"
module sas_result_bank
   import sas_pkg::*;
#(
   parameter int NUM_RES = `SAS_NUM_RES
) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire sas_result_t i_wr,
   output logic [7:0]       o_res [NUM_RES]
);
   logic [7:0] res_q [NUM_RES];
   logic [7:0] res_d [NUM_RES];

   always_comb begin
      res_d = res_q;
      if (i_wr.we) begin
         res_d[i_wr.slot] = i_wr.code;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_RES; i++) begin
            res_q[i] <= 8'h00;
         end
      end else begin
         res_q <= res_d;
      end
   end

   assign o_res = res_q;
endmodule

// ---- testbench/sas_analog_model.sv ----
// Analog input mux and comparator model for the sequencer
`timescale 1ns/1ps
module sas_analog_model (
   input  wire logic [63:0] i_levels,
   input  wire logic [7:0]  i_tap_sel,
   input  wire logic [2:0]  i_mux_sel,
   output logic             o_comp_higher
);
   logic [7:0] level;
   assign level = i_levels[i_mux_sel*8 +: 8];
   // Ties count as higher so the code settles on the level itself
   assign o_comp_higher = (level >= i_tap_sel);
endmodule

// ---- testbench/tb_sar_adc_sequencer.sv ----
// Self-checking bench for the SAR converter sequencer
`timescale 1ns/1ps
module tb_sar_adc_sequencer;
   import sas_pkg::*;
   logic        clk = 0, rst = 1, hw_stop = 0, mode_we = 0, vref = 1;
   logic [4:0]  mode_wd = 5'h00, mode_rb;
   logic [63:0] levels = 64'hFF00807F01FE0000;
   logic [7:0]  tap, r0, r1, r2, r3;
   logic [2:0]  mux;
   logic        irq, busy, comp;
   logic [31:0] seed = 32'hD6638571;
   int          failures = 0, checked = 0;
   sas_sar_adc_sequencer #(.SETTLE_CYC(2)) dut (.i_clk_sys(clk), .i_rst(rst), .i_hw_stop(hw_stop),
      .i_mode_we(mode_we), .i_mode_wdata(mode_wd), .i_reference_voltage_input(vref),
      .i_comp_higher(comp), .o_tap_sel(tap), .o_mux_sel(mux), .o_channel_mode_register(mode_rb),
      .o_result_reg_0(r0), .o_result_reg_1(r1), .o_result_reg_2(r2), .o_result_reg_3(r3),
      .o_conversion_done_irq(irq), .o_busy(busy));
   sas_analog_model far (.i_levels(levels), .i_tap_sel(tap), .i_mux_sel(mux), .o_comp_higher(comp));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] exp_code(input logic [4:0] m, input int s);
      logic [2:0] ch;
      ch = m[0] ? m[3:1] : {m[3], s[1:0]};
      return levels[ch*8 +: 8];
   endfunction
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d, failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic write_mode(input logic [4:0] m);
      @(posedge clk);
      mode_we <= 1'b1;
      mode_wd <= m;
      @(posedge clk);
      mode_we <= 1'b0;
   endtask
   // Two idle edges skip a completion pulse left over from the previous completed pass
   task automatic check_pass(input logic [4:0] m);
      int n;
      n = 0;
      repeat (2) @(posedge clk);
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      cmp({7'h00, irq}, 8'h01);
      cmp({3'h0, mode_rb}, {3'h0, m});
      cmp(r0, exp_code(m, 0));
      cmp(r1, exp_code(m, 1));
      cmp(r2, exp_code(m, 2));
      cmp(r3, exp_code(m, 3));
      @(posedge clk);
      cmp({7'h00, irq}, 8'h00);
   endtask
   initial forever #2.5 clk = ~clk;
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      complete_run();
   end
   initial begin
      logic [4:0] m;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      cmp({3'h0, mode_rb}, 8'h00);
      for (int i = 0; i < 10; i++) begin
         m = (i < 2) ? {1'b0, i[0], 3'h0} : {seed[4], i[2:0] - 3'h2, 1'b1};
         write_mode(m);
         check_pass(m);
         check_pass(m);
         seed = lfsr(seed);
         levels[31:0] <= seed;
         seed = lfsr(seed);
         levels[63:32] <= seed;
      end
      write_mode(5'h01);
      repeat (30) @(posedge clk);
      cmp({7'h00, busy}, 8'h01);
      write_mode(5'h0B);
      check_pass(5'h0B);
      vref <= 1'b0;
      repeat (20) @(posedge clk);
      cmp(tap, 8'h00);
      cmp({7'h00, busy}, 8'h00);
      cmp({5'h00, mux}, 8'h05);
      levels <= ~levels;
      vref <= 1'b1;
      check_pass(5'h0B);
      hw_stop <= 1'b1;
      repeat (3) @(posedge clk);
      cmp({3'h0, mode_rb}, 8'h00);
      hw_stop <= 1'b0;
      check_pass(5'h00);
      complete_run();
   end
endmodule
